// ==== hw/ffsup_top.sv ====
// Failsafe fault supervisor for a fieldbus valve positioner.
`timescale 1ns/10ps
`default_nettype none
`include "ffsup_map.svh"

module ffsup_top
	import ffsup_pkg::*;
#(
	parameter int PERSIST_CYC = `FFSUP_PERSIST_CYC
) (
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	// Register port
	input  wire logic [`FFSUP_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [7:0]               reg_rdata,
	// Sensor read results
	input  wire logic                     pos_read,
	input  wire logic                     pos_out_of_range,
	input  wire logic                     temp_read,
	input  wire logic                     temp_out_of_range,
	input  wire logic                     ref_read,
	input  wire logic                     ref_out_of_range,
	input  wire logic                     ref_raw_deviation,
	input  wire logic                     pilot_out_of_range,
	// Bus, initialization and network events
	input  wire logic                     bus_txn_fail,
	input  wire logic                     init_check,
	input  wire logic                     record_crc_fail,
	input  wire logic                     backup_crc_fail,
	input  wire logic                     table_crc_fail,
	input  wire logic                     signature_bad,
	input  wire logic                     preserved_valid,
	input  wire logic                     fatal_twice,
	input  wire logic                     network_fail_request,
	// Mode, failsafe and interrupt outputs
	output logic      [1:0]               transducer_mode,
	output logic                          transducer_out_of_service_mode,
	output logic                          resource_out_of_service_mode,
	output logic                          downstream_out_of_service_mode,
	output logic                          failsafe_indicate,
	output logic                          valve_failsafe_drive,
	output logic                          irq
);

	////////////////////////////////////////////////////////////////////////
	// Consecutive-read counters and fault evaluation.

	localparam int NF = `FFSUP_NFAULT;

	logic [2:0]    pos_cnt_q;
	logic [2:0]    temp_cnt_q;
	logic [2:0]    ref_cnt_q;
	logic          nvm_q;
	logic          fatal_q;
	logic          clear_pulse;
	logic [NF-1:0] cur_d;
	logic [NF-1:0] cur_q;
	logic [NF-1:0] hist_q;
	logic [NF-1:0] mask_q;
	logic [NF-1:0] stat_q;
	logic [7:0]    ctrl_q;
	logic [31:0]   persist_q;
	ffsup_state_t  state_q;
	ffsup_mode_t   mode_q;
	logic          res_halt_q;
	logic          down_halt_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pos_cnt_q <= 3'h0;
		end else if (pos_read) begin
			if (!pos_out_of_range) begin
				pos_cnt_q <= 3'h0;
			end else if (pos_cnt_q != `FFSUP_CONSEC_READS) begin
				pos_cnt_q <= pos_cnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			temp_cnt_q <= 3'h0;
		end else if (temp_read) begin
			if (!temp_out_of_range) begin
				temp_cnt_q <= 3'h0;
			end else if (temp_cnt_q != `FFSUP_CONSEC_READS) begin
				temp_cnt_q <= temp_cnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ref_cnt_q <= 3'h0;
		end else if (ref_read) begin
			if (!ref_out_of_range) begin
				ref_cnt_q <= 3'h0;
			end else if (ref_cnt_q != `FFSUP_CONSEC_READS) begin
				ref_cnt_q <= ref_cnt_q + 3'h1;
			end
		end
	end

	// Initialization results stay until the next reset or an explicit clear.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			nvm_q   <= 1'b0;
			fatal_q <= 1'b0;
		end else begin
			if (init_check && ((record_crc_fail && backup_crc_fail)
			    || table_crc_fail || signature_bad)) begin
				nvm_q <= 1'b1;
			end else if (clear_pulse) begin
				nvm_q <= 1'b0;
			end
			if (init_check && preserved_valid && fatal_twice) begin
				fatal_q <= 1'b1;
			end else if (clear_pulse) begin
				fatal_q <= 1'b0;
			end
		end
	end

	always_comb begin
		cur_d = '0;
		cur_d[`FFSUP_F_POS]   = (pos_cnt_q == `FFSUP_CONSEC_READS);
		cur_d[`FFSUP_F_TEMP]  = (temp_cnt_q == `FFSUP_CONSEC_READS);
		cur_d[`FFSUP_F_BUS]   = bus_txn_fail;
		cur_d[`FFSUP_F_NVM]   = nvm_q;
		cur_d[`FFSUP_F_REF]   = (ref_cnt_q == `FFSUP_CONSEC_READS)
		                        || ref_raw_deviation;
		cur_d[`FFSUP_F_PILOT] = pilot_out_of_range;
		cur_d[`FFSUP_F_FATAL] = fatal_q;
		cur_d[`FFSUP_F_NET]   = network_fail_request;
	end

	// Current flags follow the live condition; history and status latch.
	genvar gi;
	generate
		for (gi = 0; gi < NF; gi++) begin : g_flag
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					cur_q[gi]  <= 1'b0;
					hist_q[gi] <= 1'b0;
					stat_q[gi] <= 1'b0;
				end else begin
					cur_q[gi] <= cur_d[gi];
					if (cur_d[gi]) begin
						hist_q[gi] <= 1'b1;
					end else if (clear_pulse) begin
						hist_q[gi] <= 1'b0;
					end
					if (cur_d[gi] && !cur_q[gi]) begin
						stat_q[gi] <= 1'b1;
					end else if (reg_wr && reg_addr == `FFSUP_OFF_STAT
					             && reg_wdata[gi]) begin
						stat_q[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Control, mask and the failsafe state machine.

	logic any_fault;
	logic mode_wr;
	logic mode_exit;
	assign any_fault   = |cur_q;
	assign clear_pulse = reg_wr && reg_addr == `FFSUP_OFF_CTRL
	                     && reg_wdata[`FFSUP_CTRL_CLEAR];
	assign mode_wr     = reg_wr && reg_addr == `FFSUP_OFF_MODE;
	// Only manual or automatic with no live fault ends failsafe.
	assign mode_exit   = mode_wr && !any_fault
	                     && (reg_wdata[1:0] == FFSUP_MODE_MAN
	                     || reg_wdata[1:0] == FFSUP_MODE_AUTO);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `FFSUP_CTRL_RST;
			mask_q <= '0;
		end else begin
			if (reg_wr && reg_addr == `FFSUP_OFF_CTRL) begin
				ctrl_q <= {7'h00, reg_wdata[`FFSUP_CTRL_SPREAD]};
			end
			if (reg_wr && reg_addr == `FFSUP_OFF_MASK) begin
				mask_q <= reg_wdata;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q   <= FFSUP_ST_RUN;
			persist_q <= 32'h0000_0000;
		end else begin
			unique case (state_q)
				FFSUP_ST_RUN: begin
					persist_q <= 32'h0000_0000;
					if (any_fault) begin
						state_q <= FFSUP_ST_PEND;
					end
				end
				FFSUP_ST_PEND: begin
					if (!any_fault) begin
						state_q <= FFSUP_ST_RUN;
					end else if (persist_q >= 32'(PERSIST_CYC - 1)) begin
						state_q <= FFSUP_ST_FAILSAF;
					end else begin
						persist_q <= persist_q + 32'h0000_0001;
					end
				end
				FFSUP_ST_FAILSAF: begin
					persist_q <= 32'h0000_0000;
					if (mode_exit) begin
						state_q <= FFSUP_ST_RUN;
					end
				end
				default: begin
					state_q <= FFSUP_ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_q <= FFSUP_MODE_OUT;
		end else if (state_q == FFSUP_ST_FAILSAF) begin
			if (mode_exit) begin
				mode_q <= ffsup_mode_t'(reg_wdata[1:0]);
			end else begin
				mode_q <= FFSUP_MODE_OUT;
			end
		end else if (mode_wr && reg_wdata[1:0] != 2'h3) begin
			mode_q <= ffsup_mode_t'(reg_wdata[1:0]);
		end
	end

	// Resource then downstream, one step each.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			res_halt_q  <= 1'b0;
			down_halt_q <= 1'b0;
		end else begin
			res_halt_q  <= ctrl_q[`FFSUP_CTRL_SPREAD]
			               && state_q == FFSUP_ST_FAILSAF;
			down_halt_q <= res_halt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs and read data.

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			transducer_mode                <= 2'h0;
			transducer_out_of_service_mode <= 1'b1;
			resource_out_of_service_mode   <= 1'b0;
			downstream_out_of_service_mode <= 1'b0;
			failsafe_indicate              <= 1'b0;
			valve_failsafe_drive           <= 1'b0;
			irq                            <= 1'b0;
		end else begin
			transducer_mode                <= mode_q;
			transducer_out_of_service_mode <= (mode_q == FFSUP_MODE_OUT);
			resource_out_of_service_mode   <= res_halt_q;
			downstream_out_of_service_mode <= down_halt_q;
			failsafe_indicate              <= (state_q == FFSUP_ST_FAILSAF);
			valve_failsafe_drive           <= (state_q == FFSUP_ST_FAILSAF);
			irq                            <= |(stat_q & mask_q);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`FFSUP_OFF_CTRL: reg_rdata <= ctrl_q;
				`FFSUP_OFF_CUR:  reg_rdata <= cur_q;
				`FFSUP_OFF_HIST: reg_rdata <= hist_q;
				`FFSUP_OFF_MASK: reg_rdata <= mask_q;
				`FFSUP_OFF_STAT: reg_rdata <= stat_q;
				`FFSUP_OFF_MODE: reg_rdata <= {6'h00, mode_q};
				default:         reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence s_fs_entry;
		state_q == FFSUP_ST_FAILSAF && ctrl_q[`FFSUP_CTRL_SPREAD];
	endsequence

	AST_HALT_IN_FAILSAFE: assert property (@(posedge core_clk)
		disable iff (rst) state_q == FFSUP_ST_FAILSAF && !mode_wr
		|=> mode_q == FFSUP_MODE_OUT)
		else $error("transducer not out of service in failsafe");
	AST_REFUSE_MODE: assert property (@(posedge core_clk)
		disable iff (rst) state_q == FFSUP_ST_FAILSAF && any_fault
		|=> mode_q == FFSUP_MODE_OUT)
		else $error("working mode taken while fault present");
	AST_SPREAD_RESOURCE: assert property (@(posedge core_clk)
		disable iff (rst) s_fs_entry
		|=> ##1 resource_out_of_service_mode)
		else $error("resource not taken out of service");
	AST_DOWNSTREAM: assert property (@(posedge core_clk)
		disable iff (rst) res_halt_q
		|=> ##1 downstream_out_of_service_mode)
		else $error("downstream not taken out of service");
	AST_POS_RESET: assert property (@(posedge core_clk)
		disable iff (rst) pos_read && !pos_out_of_range
		|=> pos_cnt_q == 3'h0)
		else $error("position count not reset");
	AST_BUS_FAULT: assert property (@(posedge core_clk)
		disable iff (rst) bus_txn_fail
		|=> cur_q[`FFSUP_F_BUS] && hist_q[`FFSUP_F_BUS])
		else $error("bus fault not flagged");
	AST_NET_FAULT: assert property (@(posedge core_clk)
		disable iff (rst) network_fail_request
		|=> cur_q[`FFSUP_F_NET])
		else $error("network request not flagged");
	AST_HIST_HOLD: assert property (@(posedge core_clk)
		disable iff (rst) hist_q != 8'h00 && !clear_pulse
		|=> hist_q != 8'h00)
		else $error("history flag lost without clear");
	AST_PILOT: assert property (@(posedge core_clk)
		disable iff (rst) pilot_out_of_range
		|=> cur_q[`FFSUP_F_PILOT])
		else $error("pilot fault not flagged");

endmodule
`default_nettype wire

// ==== inc/ffsup_map.svh ====
// Offsets, field positions, reset values and timing counts of the fault supervisor.
`ifndef FFSUP_MAP_SVH
`define FFSUP_MAP_SVH

`define FFSUP_ADDR_W         4
`define FFSUP_OFF_CTRL       4'h0
`define FFSUP_OFF_CUR        4'h1
`define FFSUP_OFF_HIST       4'h2
`define FFSUP_OFF_MASK       4'h3
`define FFSUP_OFF_STAT       4'h4
`define FFSUP_OFF_MODE       4'h5

`define FFSUP_NFAULT         8
`define FFSUP_F_POS          0
`define FFSUP_F_TEMP         1
`define FFSUP_F_BUS          2
`define FFSUP_F_NVM          3
`define FFSUP_F_REF          4
`define FFSUP_F_PILOT        5
`define FFSUP_F_FATAL        6
`define FFSUP_F_NET          7

`define FFSUP_CTRL_SPREAD    0
`define FFSUP_CTRL_CLEAR     1
`define FFSUP_CTRL_RST       8'h01

`define FFSUP_CONSEC_READS   3'h5

`define FFSUP_PERSIST_US     100
`define FFSUP_CLK_MHZ        10
`define FFSUP_PERSIST_CYC    (`FFSUP_PERSIST_US * `FFSUP_CLK_MHZ)

`endif

// ==== inc/ffsup_pkg.sv ====
// Types of the fault supervisor.
`default_nettype none
package ffsup_pkg;
	typedef enum logic [1:0] {
		FFSUP_MODE_OUT  = 2'h0,
		FFSUP_MODE_MAN  = 2'h1,
		FFSUP_MODE_AUTO = 2'h2
	} ffsup_mode_t;

	typedef enum logic [1:0] {
		FFSUP_ST_RUN     = 2'b00,
		FFSUP_ST_PEND    = 2'b01,
		FFSUP_ST_FAILSAF = 2'b11
	} ffsup_state_t;
endpackage
`default_nettype wire

// ==== tb/ffsup_net_model.sv ====
// Network side model that raises a failed-state request on command.
`timescale 1ns/10ps
`default_nettype none

module ffsup_net_model (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Bench command and request towards the device
	input  wire logic fail_cmd,
	output logic      network_fail_request
);
	// The request is a level that lasts as long as the network asks.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			network_fail_request <= 1'b0;
		end else begin
			network_fail_request <= fail_cmd;
		end
	end
endmodule

`default_nettype wire

// ==== tb/tb_ffsup_top.sv ====
// Self-checking testbench of the fault supervisor.
`timescale 1ns/10ps
`default_nettype none
`include "ffsup_map.svh"

module tb_ffsup_top;
	logic       core_clk, rst, wr, rd, ini, net;
	logic [3:0] addr, lv;
	logic [7:0] wd, rdat;
	logic [2:0] rq, oor;
	logic [5:0] iv;
	logic [1:0] tmode;
	logic       toos, roos, doos, fsi, vfd, irq;
	int         mismatches, compares;
	logic [7:0] lt [4] = '{8'h10, 8'h04, 8'h20, 8'h80};
	logic [5:0] it [5] = '{6'h03, 6'h01, 6'h04, 6'h08, 6'h30};
	logic [7:0] ie [5] = '{8'h08, 8'h00, 8'h08, 8'h08, 8'h40};

	ffsup_net_model u_net (.core_clk(core_clk), .rst(rst),
		.fail_cmd(lv[3]), .network_fail_request(net));

	ffsup_top #(.PERSIST_CYC(4)) u_dut (.core_clk(core_clk), .rst(rst),
		.reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdat), .pos_read(rq[0]), .pos_out_of_range(oor[0]),
		.temp_read(rq[1]), .temp_out_of_range(oor[1]), .ref_read(rq[2]),
		.ref_out_of_range(oor[2]), .ref_raw_deviation(lv[0]),
		.pilot_out_of_range(lv[2]), .bus_txn_fail(lv[1]),
		.init_check(ini), .record_crc_fail(iv[0]),
		.backup_crc_fail(iv[1]), .table_crc_fail(iv[2]),
		.signature_bad(iv[3]), .preserved_valid(iv[4]),
		.fatal_twice(iv[5]), .network_fail_request(net),
		.transducer_mode(tmode), .transducer_out_of_service_mode(toos),
		.resource_out_of_service_mode(roos),
		.downstream_out_of_service_mode(doos), .failsafe_indicate(fsi),
		.valve_failsafe_drive(vfd), .irq(irq));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rchk(input string n, input logic [3:0] a,
		input logic [7:0] e);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 chk(n, rdat, e);
	endtask

	// Requested sensor reads: s selects position, temperature, reference.
	task automatic sense(input int s, input logic o, input int n);
		repeat (n) begin
			@(posedge core_clk);
			rq <= 3'h1 << s;
			oor <= {3{o}};
			@(posedge core_clk);
			rq <= 3'h0;
		end
	endtask

	task automatic end_of_test;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		cyc(3000);
		mismatches++;
		end_of_test();
	end

	initial begin
		{rst, wr, rd, ini, addr, wd, rq, oor, lv, iv} = '0;
		rst = 1'b1;
		mismatches = 0;
		compares = 0;
		cyc(2);
		rst <= 1'b0;
		rchk("ctrl", `FFSUP_OFF_CTRL, 8'h01);
		chk("out_of_service", {5'h00, toos, tmode}, 8'h04);
		wreg(`FFSUP_OFF_MODE, 8'h01);
		cyc(2);
		chk("mode", {5'h00, toos, tmode}, 8'h01);
		sense(0, 1'b1, 4);
		sense(0, 1'b0, 1);
		sense(0, 1'b1, 4);
		rchk("cur", `FFSUP_OFF_CUR, 8'h00);
		sense(0, 1'b1, 1);
		cyc(2);
		rchk("cur", `FFSUP_OFF_CUR, 8'h01);
		sense(1, 1'b1, 5);
		cyc(2);
		rchk("cur", `FFSUP_OFF_CUR, 8'h03);
		cyc(12);
		chk("mode", {5'h00, toos, tmode}, 8'h04);
		chk("fs", {4'h0, fsi, vfd, roos, doos}, 8'h0f);
		wreg(`FFSUP_OFF_MODE, 8'h02);
		cyc(2);
		chk("mode", {6'h00, tmode}, 8'h00);
		wreg(`FFSUP_OFF_MASK, 8'hff);
		cyc(2);
		chk("irq", {7'h00, irq}, 8'h01);
		wreg(`FFSUP_OFF_MASK, 8'h00);
		cyc(2);
		chk("irq", {7'h00, irq}, 8'h00);
		wreg(`FFSUP_OFF_MASK, 8'hff);
		rchk("stat", `FFSUP_OFF_STAT, 8'h03);
		wreg(`FFSUP_OFF_STAT, 8'h03);
		cyc(2);
		chk("irq", {7'h00, irq}, 8'h00);
		sense(0, 1'b0, 1);
		sense(1, 1'b0, 1);
		cyc(2);
		rchk("cur", `FFSUP_OFF_CUR, 8'h00);
		rchk("hist", `FFSUP_OFF_HIST, 8'h03);
		wreg(`FFSUP_OFF_CTRL, 8'h03);
		rchk("hist", `FFSUP_OFF_HIST, 8'h00);
		wreg(`FFSUP_OFF_MODE, 8'h01);
		cyc(3);
		chk("exit", {4'h0, fsi, vfd, tmode}, 8'h01);
		wreg(`FFSUP_OFF_MODE, 8'h03);
		cyc(2);
		chk("mode3_run", {6'h00, tmode}, 8'h01);
		sense(2, 1'b1, 5);
		cyc(2);
		rchk("cur", `FFSUP_OFF_CUR, 8'h10);
		sense(2, 1'b0, 1);
		wreg(`FFSUP_OFF_MODE, 8'h03);
		cyc(2);
		chk("mode3_fs", {5'h00, fsi, tmode}, 8'h04);
		for (int i = 0; i < 4; i++) begin
			lv <= 4'h1 << i;
			cyc(3);
			rchk("cur_lv", `FFSUP_OFF_CUR, lt[i]);
			lv <= 4'h0;
			cyc(3);
			rchk("cur_lv", `FFSUP_OFF_CUR, 8'h00);
		end
		for (int i = 0; i < 5; i++) begin
			iv <= it[i];
			ini <= 1'b1;
			cyc(1);
			ini <= 1'b0;
			cyc(2);
			rchk("cur_init", `FFSUP_OFF_CUR, ie[i]);
			iv <= 6'h00;
			wreg(`FFSUP_OFF_CTRL, 8'h03);
		end
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		chk("rst", {4'h0, toos, fsi, roos, doos}, 8'h08);
		wreg(`FFSUP_OFF_CTRL, 8'h00);
		lv <= 4'h8;
		cyc(16);
		chk("nospread", {5'h00, fsi, roos, doos}, 8'h04);
		lv <= 4'h0;
		end_of_test();
	end
endmodule

`default_nettype wire
